// ---- rsc_defs.svh ----
`ifndef RSC_DEFS_SVH
`define RSC_DEFS_SVH

// register indexes on the plain register port
`define RSC_ADDR_CTRL 2'h0
`define RSC_ADDR_CAUSE 2'h1

// cause register bit positions
`define RSC_BIT_RSVD 7
`define RSC_BIT_UV 6
`define RSC_BIT_SW 5
`define RSC_BIT_WD 4
`define RSC_BIT_POR 3
`define RSC_BIT_PIN 2
`define RSC_BIT_CLK 1
`define RSC_BIT_LOCK 0

// control register bit positions
`define RSC_CTL_SWRST 7
`define RSC_CTL_UVRE 2
`define RSC_CTL_UVDE 0

// reset values
`define RSC_CAUSE_RST 8'h48
`define RSC_CTRL_RST 8'h05

// timing
`define RSC_HOLD_CYCLES 512
`define RSC_PIN_EDGES 4

`endif

// ---- rsc_pkg.sv ----
`default_nettype none
package rsc_pkg;
  typedef enum logic [2:0] {
    RSC_IDLE,
    RSC_BUS_WAIT,
    RSC_PIN_WAIT,
    RSC_LOCK_WAIT,
    RSC_COUNT
  } rsc_state_t;

  typedef struct packed {
    logic [7:0] cause;
    logic por;
    logic uv;
    logic clk_fail;
    logic lock_fail;
  } rsc_async_t;

  typedef struct packed {
    rsc_state_t state;
    logic [9:0] count;
    logic [2:0] pin_sync;
    logic [2:0] pin_cnt;
    logic pin_req;
    logic [7:0] cause;
    logic [7:0] pend;
    logic sw_req;
    logic uv_re;
    logic uv_de;
    logic reset_out;
    logic cfg_latch;
    logic [7:0] rdata;
  } rsc_regs_t;
endpackage : rsc_pkg
`default_nettype wire

// ---- rsc_sequencer.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "rsc_defs.svh"
module rsc_sequencer
  import rsc_pkg::*;
#(
  parameter int HOLD_CYCLES = `RSC_HOLD_CYCLES
) (
  // clock and reset (rst_in is the power-on detector)
  input wire logic clk_in,
  input wire logic rst_in,
  // register port
  input wire logic [1:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // reset sources
  input wire logic reset_in_n,
  input wire logic stop_mode_in,
  input wire logic watchdog_in,
  input wire logic undervoltage_in,
  input wire logic pll_mode_in,
  input wire logic pll_locked_in,
  input wire logic pll_clock_fail_in,
  input wire logic clock_fail_reset_en_in,
  input wire logic lock_fail_reset_en_in,
  // bus cycle handshake
  input wire logic bus_idle_in,
  output logic busmon_force_out,
  // reset outputs
  output logic reset_out_n,
  output logic undervoltage_irq_block_out,
  output logic config_latch_out
);

  // ****************************************
  // asynchronous sources
  // ****************************************
  logic ctl_uv_de;
  logic ctl_uv_re;
  logic uv_rst;
  logic clk_fail;
  logic lock_fail;
  logic stop_pin;
  logic async_hit;

  // undervoltage reset needs both enables; when it fires it also masks the interrupt path
  assign uv_rst = undervoltage_in & ctl_uv_de & ctl_uv_re;
  assign clk_fail = pll_mode_in & clock_fail_reset_en_in & pll_clock_fail_in;
  assign lock_fail = pll_mode_in & lock_fail_reset_en_in & ~pll_locked_in;
  // the pin cannot be sampled with clocks stopped, so in stop mode it is taken raw
  assign stop_pin = stop_mode_in & ~reset_in_n;
  // internal sources skip the bus wait: a failing clock may never end the cycle
  assign async_hit = clk_fail | lock_fail | stop_pin;
  assign undervoltage_irq_block_out = uv_rst;

  // ****************************************
  // decoders
  // ****************************************
  // outside pll mode there is no lock to wait for
  function automatic logic locked_ok(input logic pll_mode, input logic locked);
    locked_ok = ~pll_mode | locked;
  endfunction : locked_ok

  // one step of the pin filter: count agreed asserted samples, saturating at the threshold
  function automatic logic [2:0] pin_step(input logic [2:0] sync, input logic [2:0] cnt);
    logic [2:0] step;
    step = cnt;
    if (sync[2] == sync[1]) begin
      if (sync[2]) begin
        if (cnt != 3'(`RSC_PIN_EDGES)) begin
          step = cnt + 3'h1;
        end
      end else begin
        step = 3'h0;
      end
    end
    pin_step = step;
  endfunction : pin_step

  // place of each synchronous source in the cause word
  function automatic logic sync_bit(input int pos, input logic [2:0] hit);
    logic found;
    found = 1'b0;
    unique case (pos)
      `RSC_BIT_PIN: found = hit[0];
      `RSC_BIT_WD: found = hit[1];
      `RSC_BIT_SW: found = hit[2];
      default: found = 1'b0;
    endcase
    sync_bit = found;
  endfunction : sync_bit

  // cause word taken on entry to reset; power-on and undervoltage never come this way
  function automatic logic [7:0] entry_cause(
    input logic [7:0] pend,
    input logic clk_loss,
    input logic lock_loss,
    input logic pin_raw
  );
    logic [7:0] word;
    word = pend;
    word[`RSC_BIT_CLK] = clk_loss;
    word[`RSC_BIT_LOCK] = lock_loss;
    word[`RSC_BIT_PIN] = pend[`RSC_BIT_PIN] | pin_raw;
    word[`RSC_BIT_POR] = 1'b0;
    word[`RSC_BIT_UV] = 1'b0;
    word[`RSC_BIT_RSVD] = 1'b0;
    entry_cause = word;
  endfunction : entry_cause

  // control word as software reads it back; unused bits read as zero
  function automatic logic [7:0] ctrl_word(input logic sw, input logic uv_re, input logic uv_de);
    logic [7:0] word;
    word = 8'h00;
    word[`RSC_CTL_SWRST] = sw;
    word[`RSC_CTL_UVRE] = uv_re;
    word[`RSC_CTL_UVDE] = uv_de;
    ctrl_word = word;
  endfunction : ctrl_word

  // read mux; the unused indexes read zero
  function automatic logic [7:0] read_mux(input logic [1:0] addr, input logic [7:0] ctrl, input logic [7:0] cause);
    logic [7:0] word;
    word = 8'h00;
    unique case (addr)
      `RSC_ADDR_CTRL: word = ctrl;
      `RSC_ADDR_CAUSE: word = cause;
      default: word = 8'h00;
    endcase
    read_mux = word;
  endfunction : read_mux

  // ****************************************
  // state
  // ****************************************
  // flow: idle -> bus wait (synchronous) or straight to pin or lock wait (internal)
  // pin wait holds until the pin is released and its filter has cleared
  // lock wait holds while the pll reports no lock; count then runs the exact hold
  // a filtered pin assertion in lock wait or count goes back to pin wait
  // undervoltage and power-on override every state and restart in lock wait
  rsc_regs_t r_ff;
  rsc_regs_t nxt_r;
  logic pin_now;
  logic hold_last;
  logic [2:0] sync_hit;
  logic [7:0] sync_set;

  assign ctl_uv_de = r_ff.uv_de;
  assign ctl_uv_re = r_ff.uv_re;
  // a change counts once the second and third stages have agreed on four asserted samples
  assign pin_now = r_ff.pin_req;

  // ****************************************
  // synchronous request capture
  // ****************************************
  // pin outside stop mode, watchdog and software share one path to the bus wait
  assign sync_hit = {r_ff.sw_req, watchdog_in, pin_now & ~stop_mode_in};
  for (genvar bit_g = 0; bit_g < 8; bit_g++) begin : g_sync_bit
    assign sync_set[bit_g] = sync_bit(bit_g, sync_hit);
  end
  // last count of the hold; the counter is exact rather than approximate
  assign hold_last = (r_ff.count == 10'(HOLD_CYCLES - 1));

  always_comb begin
    nxt_r = r_ff;
    nxt_r.rdata = 8'h00;
    nxt_r.cfg_latch = 1'b0;

    // ****************************************
    // pin filter
    // ****************************************
    nxt_r.pin_sync = {r_ff.pin_sync[1:0], ~reset_in_n};
    nxt_r.pin_cnt = pin_step(r_ff.pin_sync, r_ff.pin_cnt);
    nxt_r.pin_req = (r_ff.pin_cnt == 3'(`RSC_PIN_EDGES));

    // ****************************************
    // register port
    // ****************************************
    // only the control word is writable; the cause word has no write path at all
    if (reg_wr_in && reg_addr_in == `RSC_ADDR_CTRL) begin
      if (reg_wdata_in[`RSC_CTL_SWRST]) begin
        nxt_r.sw_req = 1'b1;
      end
      nxt_r.uv_re = reg_wdata_in[`RSC_CTL_UVRE];
      nxt_r.uv_de = reg_wdata_in[`RSC_CTL_UVDE];
    end
    if (reg_rd_in) begin
      nxt_r.rdata = read_mux(reg_addr_in, ctrl_word(r_ff.sw_req, r_ff.uv_re, r_ff.uv_de), r_ff.cause);
    end

    // ****************************************
    // pending causes
    // ****************************************
    // they accumulate until bus wait takes the record, so synchronous sources arriving together all show unless an internal source hits in idle
    nxt_r.pend = r_ff.pend | sync_set;

    // ****************************************
    // reset flow
    // ****************************************

    unique case (r_ff.state)
      RSC_IDLE: begin
        if (async_hit) begin
          nxt_r.reset_out = 1'b1;
          // nothing synchronous is logged here, so only the internal bits can show
          nxt_r.cause = entry_cause(8'h00, clk_fail, lock_fail, stop_pin);
          nxt_r.pend = 8'h00;
          nxt_r.state = stop_pin ? RSC_PIN_WAIT : RSC_LOCK_WAIT;
        end else if (nxt_r.pend != 8'h00) begin
          nxt_r.state = RSC_BUS_WAIT;
        end
      end
      RSC_BUS_WAIT: begin
        // bus monitor guarantees termination, so writes in flight finish
        if (bus_idle_in || async_hit) begin
          nxt_r.reset_out = 1'b1;
          // a clock or lock loss met here is logged beside the synchronous bits
          nxt_r.cause = entry_cause(nxt_r.pend, clk_fail, lock_fail, 1'b0);
          nxt_r.pend = 8'h00;
          nxt_r.sw_req = 1'b0;
          nxt_r.state = RSC_PIN_WAIT;
        end
      end
      RSC_PIN_WAIT: begin
        if (reset_in_n && !r_ff.pin_req) begin
          nxt_r.state = RSC_LOCK_WAIT;
        end
      end
      RSC_LOCK_WAIT: begin
        nxt_r.count = 10'h000;
        if (r_ff.pin_req) begin
          nxt_r.state = RSC_PIN_WAIT;
        end else if (locked_ok(pll_mode_in, pll_locked_in)) begin
          nxt_r.state = RSC_COUNT;
        end
      end
      RSC_COUNT: begin
        nxt_r.count = r_ff.count + 10'h001;
        if (r_ff.pin_req) begin
          nxt_r.state = RSC_PIN_WAIT;
        end else if (!locked_ok(pll_mode_in, pll_locked_in) || pll_clock_fail_in) begin
          nxt_r.state = RSC_LOCK_WAIT;
        end else if (hold_last) begin
          nxt_r.cfg_latch = 1'b1;
          nxt_r.reset_out = 1'b0;
          nxt_r.sw_req = 1'b0;
          nxt_r.pend = 8'h00;
          nxt_r.state = RSC_IDLE;
        end
      end
      default: begin
        nxt_r.state = RSC_IDLE;
      end
    endcase

    // ****************************************
    // undervoltage override
    // ****************************************
    // undervoltage restarts from the top and owns the cause record
    if (uv_rst) begin
      nxt_r.state = RSC_LOCK_WAIT;
      nxt_r.reset_out = 1'b1;
      nxt_r.cause = 8'h00;
      nxt_r.cause[`RSC_BIT_UV] = 1'b1;
      nxt_r.pend = 8'h00;
      nxt_r.sw_req = 1'b0;
      nxt_r.count = 10'h000;
    end
  end

  // ****************************************
  // register update
  // ****************************************
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      // power-on: whole sequence from the start
      r_ff.state <= RSC_LOCK_WAIT;
      r_ff.count <= 10'h000;
      r_ff.pin_sync <= 3'h0;
      r_ff.pin_cnt <= 3'h0;
      r_ff.pin_req <= 1'b0;
      r_ff.cause <= `RSC_CAUSE_RST;
      r_ff.pend <= 8'h00;
      r_ff.sw_req <= 1'b0;
      r_ff.uv_re <= 1'b1;
      r_ff.uv_de <= 1'b1;
      r_ff.reset_out <= 1'b1;
      r_ff.cfg_latch <= 1'b0;
      r_ff.rdata <= 8'h00;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign reg_rdata_out = r_ff.rdata;
  assign reset_out_n = ~r_ff.reset_out;
  assign busmon_force_out = (r_ff.state == RSC_BUS_WAIT);
  assign config_latch_out = r_ff.cfg_latch;

endmodule : rsc_sequencer
`default_nettype wire

// ---- rsc_pin_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module rsc_pin_model (
  // clock and request
  input wire logic clk_in,
  input wire logic go_in,
  // reset pin, pulled up when released
  output logic pin_out_n
);
  int left = 0;
  always @(posedge clk_in) begin
    if (go_in) begin
      left <= 6;
    end else if (left > 0) begin
      left <= left - 1;
    end
  end
  assign pin_out_n = (left == 0);
endmodule : rsc_pin_model
`default_nettype wire

// ---- rsc_sequencer_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module rsc_sequencer_asserts #(
  parameter int HOLD_CYCLES = 512
) (
  // clock, reset and sources
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic undervoltage_in,
  input wire logic pll_mode_in,
  input wire logic pll_locked_in,
  input wire logic pll_clock_fail_in,
  input wire logic clock_fail_reset_en_in,
  input wire logic lock_fail_reset_en_in,
  input wire logic bus_idle_in,
  input wire logic reg_rd_in,
  input wire logic [1:0] reg_addr_in,
  // outputs
  input wire logic [7:0] reg_rdata_out,
  input wire logic busmon_force_out,
  input wire logic reset_out_n,
  input wire logic undervoltage_irq_block_out,
  input wire logic config_latch_out
);
  logic [15:0] low_cnt_ff;
  // a counter, since the hold is far beyond any repetition count
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      low_cnt_ff <= 16'h0000;
    end else begin
      low_cnt_ff <= reset_out_n ? 16'h0000 : low_cnt_ff + 16'h0001;
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  a_bus_end_assert: assert property (busmon_force_out && bus_idle_in |=> !reset_out_n)
    else $error("reset not asserted after bus end");
  a_bus_wait_hold: assert property (busmon_force_out && !bus_idle_in && pll_locked_in && $past(pll_locked_in)
    && !pll_clock_fail_in && !undervoltage_in
    |=> reset_out_n)
    else $error("reset asserted inside bus cycle");
  a_clk_fail_rst: assert property (pll_mode_in && clock_fail_reset_en_in && pll_clock_fail_in
    |-> ##[1:2] !reset_out_n)
    else $error("clock loss gave no reset");
  a_lock_fail_rst: assert property (pll_mode_in && lock_fail_reset_en_in && !pll_locked_in
    |-> ##[1:2] !reset_out_n)
    else $error("lock loss gave no reset");
  a_uv_reset_now: assert property ($rose(undervoltage_in) |-> ##[1:2] !reset_out_n)
    else $error("undervoltage gave no reset");
  a_hold_count: assert property ($rose(reset_out_n) |-> low_cnt_ff >= 16'(HOLD_CYCLES))
    else $error("reset hold too short");
  a_cfg_pulse: assert property (config_latch_out == $rose(reset_out_n))
    else $error("config pulse misplaced");
  a_rd_reserved: assert property (reg_rd_in && reg_addr_in == 2'h1 |=> !reg_rdata_out[7])
    else $error("reserved cause bit set");
  a_uv_irq_block: assert property (undervoltage_irq_block_out |-> undervoltage_in)
    else $error("irq blocked without undervoltage");
endmodule : rsc_sequencer_asserts
bind rsc_sequencer rsc_sequencer_asserts #(.HOLD_CYCLES(HOLD_CYCLES)) chk_u (.clk_in, .rst_in, .undervoltage_in,
  .pll_mode_in, .pll_locked_in, .pll_clock_fail_in, .clock_fail_reset_en_in, .lock_fail_reset_en_in, .bus_idle_in,
  .reg_rd_in, .reg_addr_in, .reg_rdata_out, .busmon_force_out, .reset_out_n, .undervoltage_irq_block_out,
  .config_latch_out);
`default_nettype wire

// ---- rsc_sequencer_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module rsc_sequencer_test;
  localparam int HOLD = 8;
  logic clk_in = 1'b0, rst_in = 1'b1, reg_wr_in = 1'b0, reg_rd_in = 1'b0, go = 1'b0;
  logic [1:0] reg_addr_in = 2'h0;
  logic [7:0] reg_wdata_in = 8'h00, rd;
  logic stop_mode_in = 1'b0, watchdog_in = 1'b0, undervoltage_in = 1'b0, pll_locked_in = 1'b1;
  logic pll_clock_fail_in = 1'b0, bus_idle_in = 1'b1;
  logic [7:0] exp_tab [8] = '{8'h20, 8'h10, 8'h04, 8'h04, 8'h02, 8'h01, 8'h40, 8'h21};
  logic [7:0] exp_q [$];
  wire logic [7:0] reg_rdata_out;
  wire logic reset_in_n, busmon_force_out, reset_out_n, undervoltage_irq_block_out, config_latch_out;
  int error_cnt = 0, check_count = 0;
  rsc_sequencer #(.HOLD_CYCLES(HOLD)) dut_u (.clk_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .reg_rd_in, .reg_rdata_out, .reset_in_n, .stop_mode_in, .watchdog_in, .undervoltage_in, .pll_mode_in(1'b1),
    .pll_locked_in, .pll_clock_fail_in, .clock_fail_reset_en_in(1'b1), .lock_fail_reset_en_in(1'b1),
    .bus_idle_in, .busmon_force_out, .reset_out_n, .undervoltage_irq_block_out, .config_latch_out);
  rsc_pin_model pin_u (.clk_in, .go_in(go), .pin_out_n(reset_in_n));
  always #4 clk_in = ~clk_in;
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_reg
  task automatic chk_hold(input int got);
    check_count++;
    if (got < HOLD + 1 || got > HOLD + 40) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, HOLD + 1);
    end
  endtask : chk_hold
  task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [1:0] a);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1 rd = reg_rdata_out;
    @(posedge clk_in);
  endtask : reg_read
  // waits out one reset sequence, then checks hold time and logged cause
  task automatic settle();
    int n;
    n = 0;
    while (reset_out_n !== 1'b0 && n < 40) begin
      @(posedge clk_in);
      n++;
    end
    n = 0;
    while (reset_out_n !== 1'b1 && n < 300) begin
      @(posedge clk_in);
      n++;
    end
    chk_hold(n);
    chk_reg({7'h00, config_latch_out}, 8'h01);
    reg_read(2'h1);
    chk_reg(rd, exp_q.pop_front());
    reg_read(2'h0);
    chk_reg(rd, 8'h05);
  endtask : settle
  task automatic run_kind(input int k);
    exp_q.push_back(exp_tab[k]);
    bus_idle_in <= !(k inside {0, 1, 2, 7});
    stop_mode_in <= (k == 3);
    case (k)
      0, 7: reg_write(2'h0, 8'h85);
      1: watchdog_in <= 1'b1;
      2, 3: go <= 1'b1;
      4: pll_clock_fail_in <= 1'b1;
      5: pll_locked_in <= 1'b0;
      default: undervoltage_in <= 1'b1;
    endcase
    @(posedge clk_in);
    watchdog_in <= 1'b0;
    go <= 1'b0;
    repeat (8 + $urandom % 4) @(posedge clk_in);
    if (k != 2) begin
      chk_reg({6'h00, undervoltage_irq_block_out, busmon_force_out}, {6'h00, k == 6, k inside {0, 1, 7}});
    end
    if (k == 7) begin
      pll_locked_in <= 1'b0;
      repeat (2) @(posedge clk_in);
    end
    pll_locked_in <= 1'b1;
    {pll_clock_fail_in, undervoltage_in, stop_mode_in, bus_idle_in} <= 4'h1;
    settle();
  endtask : run_kind
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    void'($urandom(32'h55EA));
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    exp_q.push_back(8'h48);
    settle();
    reg_write(2'h1, 8'($urandom));
    reg_read(2'h1);
    chk_reg(rd, 8'h48);
    reg_read(2'h3);
    chk_reg(rd, 8'h00);
    for (int k = 0; k < 8; k++) begin
      run_kind(k);
    end
    report_and_stop();
  end
  initial begin
    #100000;
    error_cnt++;
    report_and_stop();
  end
endmodule : rsc_sequencer_test
`default_nettype wire
